/* File: hw/dtm_cfg.svh */
// constants for the dual 8-bit cascadable timer: offsets, fields, reset values
// assumes a 32-bit classic wishbone slave with register index times four as byte address
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH
`define DTM_IDX_T0_DATA_LO 8'h68
`define DTM_IDX_T0_DATA_HI 8'h69
`define DTM_IDX_T1_DATA_LO 8'h6a
`define DTM_IDX_T1_DATA_HI 8'h6b
`define DTM_IDX_T0_CNT_LO 8'h6c
`define DTM_IDX_T0_CNT_HI 8'h6d
`define DTM_IDX_T1_CNT_LO 8'h6e
`define DTM_IDX_T1_CNT_HI 8'h6f
`define DTM_IDX_T0_MODE 8'h70
`define DTM_IDX_T0_CLK 8'h71
`define DTM_IDX_T1_MODE 8'h72
`define DTM_IDX_T1_CLK 8'h73
`define DTM_IDX_T0_STAT 8'h74
`define DTM_IDX_T1_STAT 8'h75
`define DTM_IDX_IRQ_MASK 8'h76
`define DTM_NIB_RESET 4'h0
`define DTM_BIT_CAP 1
`define DTM_BIT_OVF 0
`define DTM_CLK_LOW 3'h0
`define DTM_CLK_HIGH 3'h1
`define DTM_CLK_T0_EXT 3'h7
`define DTM_CLK_T1_EXT 3'h6
`define DTM_CLK_T1_CASC 3'h7
`endif

/* File: hw/dtm_pkg.sv */
// types for the dual 8-bit cascadable timer
// used by the single timer module
package dtm_pkg;
  // mode field of both timers, binary-ordered along stop to run
  typedef enum logic [2:0] {
    DTM_RELOAD_STOP = 3'h0,
    DTM_RELOAD_RUN = 3'h1,
    DTM_CAPTURE_STOP = 3'h2,
    DTM_CAPTURE_RUN = 3'h3,
    DTM_FREQ_RUN = 3'h4
  } dtm_mode_t;
endpackage : dtm_pkg

/* File: hw/dtm_timer.sv */
// dual 8-bit timer pair, cascadable to 16 bits, on a classic wishbone slave
// assumes count clock sources arrive synchronous to mclk as levels
//
// Functional notes
// - two independent timers, zero and one, each with an eight-bit count
// - chained mode clocks timer one from timer zero overflow
// - auto-reload mode reloads counter from data register on overflow
// - capture mode stores the captured count in the data register
// - capture mode data write copies counter into data, ignoring written value
// - counter write also loads data; data write leaves counter alone
// - counter is eight-bit up-counter split in two writable nibbles
// - reset clears data, counter and control registers of both timers
// - mode field decodes reload, capture, frequency, stopped or running
// - clock field selects low, high, divided high, or external clock
// - each timer has its own external clock pin
// - capture pin change sets flag, blocks captures; status read clears it
// - overflow flag toggles on each overflow, zero after reset
// - external clock sampled by system clock; levels last over one cycle
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`include "dtm_cfg.svh"
module dtm_timer
  import dtm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_speed_base_clock,
  input wire logic high_speed_clock,
  input wire logic t0_ext_clock_pin,
  input wire logic t1_ext_clock_pin,
  input wire logic t0_capture_pin,
  input wire logic t1_capture_pin,
  output logic irq
);

  logic [7:0] data_q [2];
  logic [7:0] cnt_q [2];
  logic [3:0] mode_q [2];
  logic [3:0] csel_q [2];
  logic [1:0] cap_q;
  logic [1:0] ovf_q;
  logic [3:0] mask_q;
  logic [4:0] hdiv_q;
  logic [7:0] src_q;
  logic [7:0] src_prev_q;
  logic [1:0] cpin_q;
  logic [1:0] ovf_pulse;
  logic [1:0] tick;
  logic [1:0] capev;
  // timer one pin history is declared here because the tick decode reads it first
  logic t1ext_prev_q;
  logic t1ext_q;
  logic cpin_t1ext_rise;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [3:0] wnib;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd = acc && !wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wnib = wb_dat_i[3:0];

  // running decode of a mode nibble; unused codes leave the timer still
  function automatic logic is_run(input logic [3:0] m);
    is_run = (m[2:0] == DTM_RELOAD_RUN) || (m[2:0] == DTM_CAPTURE_RUN) || (m[2:0] == DTM_FREQ_RUN);
  endfunction : is_run

  function automatic logic is_cap(input logic [3:0] m);
    is_cap = m[2:1] == 2'b01;
  endfunction : is_cap

  // pick a count source: raw level from the source register for clock select
  function automatic logic pick(input logic [2:0] s, input logic [7:0] lv);
    pick = lv[s];
  endfunction : pick

  // high-speed divider; bit k is high_speed_clock divided by 2^(k+1)
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hdiv_q <= 5'h00;
    end else if (high_speed_clock && !src_q[`DTM_CLK_HIGH]) begin
      hdiv_q <= hdiv_q + 5'h01;
    end
  end

  // sampled source levels: low, high, /2../32, ext; timer one replaces slots 6 and 7
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_q <= 8'h00;
      src_prev_q <= 8'h00;
      cpin_q <= 2'b00;
    end else begin
      src_q <= {t0_ext_clock_pin, hdiv_q, high_speed_clock, low_speed_base_clock};
      src_prev_q <= src_q;
      cpin_q <= {t1_capture_pin, t0_capture_pin};
    end
  end

  // rising edge of the selected source makes one count tick
  always_comb begin
    logic [7:0] t1lv;
    logic [7:0] t1pv;
    t1lv = src_q;
    t1pv = src_prev_q;
    t1lv[`DTM_CLK_T1_EXT] = t1_ext_clock_pin;
    t1pv[`DTM_CLK_T1_EXT] = src_q[`DTM_CLK_T0_EXT];
    tick[0] = is_run(mode_q[0]) && pick(csel_q[0][2:0], src_q) && !pick(csel_q[0][2:0], src_prev_q);
    // t1 slot 6 edge compares live pin to t0 pin history only when unused; reuse own history below
    tick[1] = is_run(mode_q[1]) && ((csel_q[1][2:0] == `DTM_CLK_T1_CASC) ? ovf_pulse[0] :
      (csel_q[1][2:0] == `DTM_CLK_T1_EXT) ? (cpin_t1ext_rise) :
      (pick(csel_q[1][2:0], t1lv) && !pick(csel_q[1][2:0], t1pv)));
    capev[0] = is_cap(mode_q[0]) && is_run(mode_q[0]) && (cpin_q[0] != t0_capture_pin) && !cap_q[0];
    capev[1] = is_cap(mode_q[1]) && is_run(mode_q[1]) && (cpin_q[1] != t1_capture_pin) && !cap_q[1];
  end

  // timer one external pin has its own edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      t1ext_q <= 1'b0;
      t1ext_prev_q <= 1'b0;
    end else begin
      t1ext_q <= t1_ext_clock_pin;
      t1ext_prev_q <= t1ext_q;
    end
  end
  assign cpin_t1ext_rise = t1ext_q && !t1ext_prev_q;

  assign ovf_pulse[0] = tick[0] && (cnt_q[0] == 8'hff);
  assign ovf_pulse[1] = tick[1] && (cnt_q[1] == 8'hff);

  // counters, data registers and controls of both timers
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    localparam logic [7:0] DLO = t ? `DTM_IDX_T1_DATA_LO : `DTM_IDX_T0_DATA_LO;
    localparam logic [7:0] DHI = t ? `DTM_IDX_T1_DATA_HI : `DTM_IDX_T0_DATA_HI;
    localparam logic [7:0] CLO = t ? `DTM_IDX_T1_CNT_LO : `DTM_IDX_T0_CNT_LO;
    localparam logic [7:0] CHI = t ? `DTM_IDX_T1_CNT_HI : `DTM_IDX_T0_CNT_HI;
    localparam logic [7:0] MOD = t ? `DTM_IDX_T1_MODE : `DTM_IDX_T0_MODE;
    localparam logic [7:0] CKS = t ? `DTM_IDX_T1_CLK : `DTM_IDX_T0_CLK;
    localparam logic [7:0] STA = t ? `DTM_IDX_T1_STAT : `DTM_IDX_T0_STAT;

    // count: software write wins over a tick in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_q[t] <= 8'h00;
      end else if (wr && idx == CLO) begin
        cnt_q[t][3:0] <= wnib;
      end else if (wr && idx == CHI) begin
        cnt_q[t][7:4] <= wnib;
      end else if (tick[t]) begin
        if (cnt_q[t] == 8'hff && !is_cap(mode_q[t])) begin
          cnt_q[t] <= data_q[t];
        end else begin
          cnt_q[t] <= cnt_q[t] + 8'h01;
        end
      end
    end

    // data: reload value or captured count
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        data_q[t] <= 8'h00;
      end else if (wr && idx == CLO) begin
        data_q[t][3:0] <= wnib;
      end else if (wr && idx == CHI) begin
        data_q[t][7:4] <= wnib;
      end else if (wr && (idx == DLO || idx == DHI)) begin
        if (is_cap(mode_q[t])) begin
          data_q[t] <= cnt_q[t];
        end else if (idx == DLO) begin
          data_q[t][3:0] <= wnib;
        end else begin
          data_q[t][7:4] <= wnib;
        end
      end else if (capev[t]) begin
        data_q[t] <= cnt_q[t];
      end
    end

    // control nibbles; bit 3 is not implemented
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mode_q[t] <= `DTM_NIB_RESET;
        csel_q[t] <= `DTM_NIB_RESET;
      end else begin
        if (wr && idx == MOD) begin
          mode_q[t] <= {1'b0, wnib[2:0]};
        end
        if (wr && idx == CKS) begin
          csel_q[t] <= {1'b0, wnib[2:0]};
        end
      end
    end

    // status flags: capture is sticky and read-cleared, but a new event wins
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cap_q[t] <= 1'b0;
        ovf_q[t] <= 1'b0;
      end else begin
        if (capev[t]) begin
          cap_q[t] <= 1'b1;
        end else if (rd && idx == STA) begin
          cap_q[t] <= 1'b0;
        end
        if (ovf_pulse[t]) begin
          ovf_q[t] <= !ovf_q[t];
        end
      end
    end
  end

  // interrupt mask and output: capture flags of both timers are the events
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      if (wr && idx == `DTM_IDX_IRQ_MASK) begin
        mask_q <= wnib;
      end
      irq <= |({cap_q[1], 1'b0, cap_q[0], 1'b0} & mask_q);
    end
  end

  // read mux, nibble in low bits
  function automatic logic [3:0] rdnib(input logic [7:0] a);
    unique case (a)
      `DTM_IDX_T0_DATA_LO: rdnib = data_q[0][3:0];
      `DTM_IDX_T0_DATA_HI: rdnib = data_q[0][7:4];
      `DTM_IDX_T1_DATA_LO: rdnib = data_q[1][3:0];
      `DTM_IDX_T1_DATA_HI: rdnib = data_q[1][7:4];
      `DTM_IDX_T0_CNT_LO: rdnib = cnt_q[0][3:0];
      `DTM_IDX_T0_CNT_HI: rdnib = cnt_q[0][7:4];
      `DTM_IDX_T1_CNT_LO: rdnib = cnt_q[1][3:0];
      `DTM_IDX_T1_CNT_HI: rdnib = cnt_q[1][7:4];
      `DTM_IDX_T0_MODE: rdnib = mode_q[0];
      `DTM_IDX_T0_CLK: rdnib = csel_q[0];
      `DTM_IDX_T1_MODE: rdnib = mode_q[1];
      `DTM_IDX_T1_CLK: rdnib = csel_q[1];
      `DTM_IDX_T0_STAT: rdnib = {2'b00, cap_q[0], ovf_q[0]};
      `DTM_IDX_T1_STAT: rdnib = {2'b00, cap_q[1], ovf_q[1]};
      `DTM_IDX_IRQ_MASK: rdnib = mask_q;
      default: rdnib = 4'h0; // unmapped reads zero, still acked
    endcase
  endfunction : rdnib

  // wishbone answer one cycle after the strobe, dropped the cycle after
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? {28'h000_0000, rdnib(idx)} : 32'h0000_0000;
    end
  end

  // checks
  AST_OVF_TOGGLE: assert property (@(posedge mclk) disable iff (rst) ovf_pulse[0] |=> ovf_q[0] != $past(ovf_q[0]))
    else $error("t0 overflow flag did not toggle");
  AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (!is_run(mode_q[0]) && !wr) |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("stopped t0 counter moved");
  AST_CNT_WR_DATA: assert property (@(posedge mclk) disable iff (rst)
    (wr && idx == `DTM_IDX_T0_CNT_LO) |=> data_q[0][3:0] == $past(wnib))
    else $error("counter write did not reach data");
  AST_DATA_WR_CNT: assert property (@(posedge mclk) disable iff (rst)
    (wr && idx == `DTM_IDX_T0_DATA_LO && !tick[0]) |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("data write changed counter");
  AST_CAP_COPY: assert property (@(posedge mclk) disable iff (rst)
    (wr && idx == `DTM_IDX_T1_DATA_HI && is_cap(mode_q[1])) |=> data_q[1] == $past(cnt_q[1]))
    else $error("capture mode data write did not copy counter");
  AST_RELOAD: assert property (@(posedge mclk) disable iff (rst)
    (ovf_pulse[0] && !is_cap(mode_q[0]) && !wr) |=> cnt_q[0] == $past(data_q[0]))
    else $error("reload value not loaded");
  AST_CASCADE: assert property (@(posedge mclk) disable iff (rst)
    (csel_q[1][2:0] == `DTM_CLK_T1_CASC && is_run(mode_q[1])) |-> tick[1] == ovf_pulse[0])
    else $error("cascade tick mismatch");
  AST_CAP_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    cap_q[0] |-> !capev[0])
    else $error("capture while flag set");
  AST_CAP_SET: assert property (@(posedge mclk) disable iff (rst)
    capev[0] |=> cap_q[0] && data_q[0] == $past(cnt_q[0]))
    else $error("capture not stored");
  AST_ACK: assert property (@(posedge mclk) disable iff (rst) wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // timer one mirrors the overflow, stop, reload and capture-block checks of timer zero; a bug in the generate index would show here
  AST_T1_OVF_TOGGLE: assert property (@(posedge mclk) disable iff (rst)
    ovf_pulse[1] |=> ovf_q[1] != $past(ovf_q[1]))
    else $error("t1 overflow flag did not toggle");
  AST_T1_STOP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (!is_run(mode_q[1]) && !wr) |=> cnt_q[1] == $past(cnt_q[1]))
    else $error("stopped t1 counter moved");
  AST_T1_RELOAD: assert property (@(posedge mclk) disable iff (rst)
    (ovf_pulse[1] && !is_cap(mode_q[1]) && !wr) |=> cnt_q[1] == $past(data_q[1]))
    else $error("t1 reload value not loaded");
  AST_T1_CAP_BLOCK: assert property (@(posedge mclk) disable iff (rst)
    cap_q[1] |-> !capev[1])
    else $error("t1 capture while flag set");

  // a status read clears the capture flag unless a new capture lands in the same cycle
  AST_CAP_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (rd && idx == `DTM_IDX_T0_STAT && !capev[0]) |=> !cap_q[0])
    else $error("status read left capture flag set");
  AST_T1_CAP_SET: assert property (@(posedge mclk) disable iff (rst)
    (capev[1] && !wr) |=> cap_q[1] && data_q[1] == $past(cnt_q[1]))
    else $error("t1 capture not stored");

  // interrupt is a registered copy, so it trails a masked flag by one cycle
  AST_IRQ_RAISE: assert property (@(posedge mclk) disable iff (rst)
    (cap_q[0] && mask_q[1]) |=> irq)
    else $error("masked-in capture flag did not raise irq");
  AST_IRQ_QUIET: assert property (@(posedge mclk) disable iff (rst)
    (!cap_q[0] && !cap_q[1]) |=> !irq)
    else $error("irq high with no capture flag");

  // read data is zero outside a read answer, so a stale nibble never leaks
  AST_DAT_IDLE: assert property (@(posedge mclk) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside an answer");

  COV_OVF: cover property (@(posedge mclk) disable iff (rst) ovf_pulse[0]);
  COV_T1_EXT: cover property (@(posedge mclk) disable iff (rst) tick[1] && csel_q[1][2:0] == `DTM_CLK_T1_EXT);
  COV_CAP_CLR: cover property (@(posedge mclk) disable iff (rst) cap_q[0] && rd && idx == `DTM_IDX_T0_STAT);
  COV_CASC: cover property (@(posedge mclk) disable iff (rst) tick[1] && csel_q[1][2:0] == `DTM_CLK_T1_CASC);
  COV_CAP: cover property (@(posedge mclk) disable iff (rst) capev[1]);

endmodule : dtm_timer

/* File: testbench/dtm_src_model.sv */
// count clock and capture pin sources seen by the timer pair
// assumes one mclk domain; all levels change just after a rising mclk edge
`timescale 1ns/10ps
module dtm_src_model (
  input wire logic mclk,
  output logic low_speed_base_clock,
  output logic high_speed_clock,
  output logic t0_ext_clock_pin,
  output logic t1_ext_clock_pin,
  output logic t0_capture_pin,
  output logic t1_capture_pin
);
  logic [6:0] div_q = 7'h00;
  initial begin
    t0_ext_clock_pin = 1'b0;
    t1_ext_clock_pin = 1'b0;
    t0_capture_pin = 1'b0;
    t1_capture_pin = 1'b0;
  end
  // free sources; fast oscillator treated as settled from time zero
  always_ff @(posedge mclk) begin
    div_q <= div_q + 7'h01;
    high_speed_clock <= div_q[1];
    low_speed_base_clock <= div_q[6];
  end
  // high level lasts three mclk cycles and low level four, so the sampler never misses one
  task automatic ext_pulse(input int tmr, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (tmr == 0) t0_ext_clock_pin <= 1'b1;
      else t1_ext_clock_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      t0_ext_clock_pin <= 1'b0;
      t1_ext_clock_pin <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
  endtask : ext_pulse
  // a level change of either kind is a capture event
  task automatic cap_toggle(input int tmr);
    @(posedge mclk);
    if (tmr == 0) t0_capture_pin <= ~t0_capture_pin;
    else t1_capture_pin <= ~t1_capture_pin;
    repeat (4) @(posedge mclk);
  endtask : cap_toggle
endmodule : dtm_src_model

/* File: testbench/dtm_timer_tb_top.sv */
// bench top: wishbone master tasks and an integer model of both timers
// assumes dtm_cfg.svh on the include path and the source model beside it
`timescale 1ns/10ps
module dtm_timer_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] dout, rdat;
  logic ack, irq, ls, hs, e0, e1, p0, p1;
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'hcc196897;
  int dm[2], cm[2], om[2], fm[2], mm[2], casc, t, v;
  always #4 mclk = ~mclk;
  dtm_timer DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(dout), .wb_ack_o(ack),
    .low_speed_base_clock(ls), .high_speed_clock(hs), .t0_ext_clock_pin(e0), .t1_ext_clock_pin(e1),
    .t0_capture_pin(p0), .t1_capture_pin(p1), .irq(irq));
  dtm_src_model SRC (.mclk(mclk), .low_speed_base_clock(ls), .high_speed_clock(hs), .t0_ext_clock_pin(e0),
    .t1_ext_clock_pin(e1), .t0_capture_pin(p0), .t1_capture_pin(p1));
  task automatic close_out();
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(string nm, int e, logic [7:0] g);
    checks_done++;
    if (g !== 8'(e)) begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic xf(logic we, int idx, int wd);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= 32'(idx) << 2;
    wb_dat_i <= 32'(wd);
    wb_sel_i <= 4'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdat = dout;
    if (n >= 40) err_total++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= $random(seed);
  endtask : xf
  task automatic rc(string nm, int idx, int e);
    xf(1'b0, idx, 0);
    chk(nm, e, rdat[7:0]);
  endtask : rc
  task automatic wc(int tm, int val);
    xf(1'b1, 'h6c + 2 * tm, val & 15);
    xf(1'b1, 'h6d + 2 * tm, val >> 4);
    cm[tm] = val;
    dm[tm] = val;
  endtask : wc
  // reading status clears the model's capture flag too
  task automatic ct(int tm);
    rc("data_lo", 'h68 + 2 * tm, dm[tm] & 15);
    rc("data_hi", 'h69 + 2 * tm, dm[tm] >> 4);
    rc("count_lo", 'h6c + 2 * tm, cm[tm] & 15);
    rc("count_hi", 'h6d + 2 * tm, cm[tm] >> 4);
    rc("status", 'h74 + tm, fm[tm] * 2 + om[tm]);
    fm[tm] = 0;
  endtask : ct
  // stopped modes ignore ticks; capture wraps to zero, others reload
  function automatic void tick(int tm);
    if (mm[tm] % 2 == 1 || mm[tm] == 4) begin
      if (cm[tm] == 255) begin
        om[tm] ^= 1;
        cm[tm] = (mm[tm] == 3) ? 0 : dm[tm];
        if (tm == 0 && casc == 1) tick(1);
      end else cm[tm]++;
    end
  endfunction : tick
  task automatic pz(int tm, int n);
    SRC.ext_pulse(tm, n);
    repeat (n) tick(tm);
  endtask : pz
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 'h68; i <= 'h77; i++) rc("reset", i, 0);
    xf(1'b1, 'h7f, 15);
    rc("unmapped", 'h7f, 0);
    for (int i = 0; i < 8; i++) begin
      xf(1'b1, 'h71, 8 + i);
      rc("clk_sel", 'h71, i);
    end
    for (int i = 0; i < 5; i++) begin
      xf(1'b1, 'h70, i);
      rc("mode_sel", 'h70, i);
    end
    xf(1'b1, 'h70, 0);
    repeat (6) begin
      t = $random(seed) & 1;
      v = $random(seed) & 255;
      wc(t, v);
      dm[t] = (v & 'hf0) | (v ^ 5) & 15;
      xf(1'b1, 'h68 + 2 * t, dm[t] & 15);
      ct(t);
    end
    wc(0, 'hfd);
    xf(1'b1, 'h69, 2);
    xf(1'b1, 'h68, 0);
    dm[0] = 'h20;
    pz(0, 3);
    ct(0);
    xf(1'b1, 'h70, 1);
    mm[0] = 1;
    pz(0, 3);
    ct(0);
    xf(1'b1, 'h73, 7);
    xf(1'b1, 'h72, 1);
    mm[1] = 1;
    casc = 1;
    wc(1, 0);
    wc(0, 'hff);
    pz(0, 3);
    ct(0);
    ct(1);
    xf(1'b1, 'h73, 6);
    casc = 0;
    pz(1, 2);
    ct(1);
    xf(1'b1, 'h70, 3);
    mm[0] = 3;
    wc(0, 'h40);
    xf(1'b1, 'h76, 2);
    pz(0, 2);
    SRC.cap_toggle(0);
    dm[0] = cm[0];
    fm[0] = 1;
    chk("irq_set", 1, {7'h0, irq});
    pz(0, 2);
    SRC.cap_toggle(0);
    ct(0);
    repeat (3) @(posedge mclk);
    chk("irq_clear", 0, {7'h0, irq});
    xf(1'b1, 'h68, 0);
    dm[0] = cm[0];
    ct(0);
    wc(0, 'hff);
    pz(0, 1);
    ct(0);
    xf(1'b1, 'h72, 3);
    mm[1] = 3;
    xf(1'b1, 'h76, 8);
    SRC.cap_toggle(1);
    dm[1] = cm[1];
    fm[1] = 1;
    chk("irq_t1", 1, {7'h0, irq});
    ct(1);
    repeat (3) @(posedge mclk);
    chk("irq_t1_clear", 0, {7'h0, irq});
    close_out();
  end
  // whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    close_out();
  end
endmodule : dtm_timer_tb_top
